/* File: utd_defines.svh */
// constants for the transmit-command decoder
`ifndef UTD_DEFINES_SVH
`define UTD_DEFINES_SVH
`define UTD_CODE_MSB 7
`define UTD_CODE_LSB 6
`define UTD_PAY_MSB 5
`define UTD_PAY_LSB 0
`define UTD_PAY_NONE 6'h00
`define UTD_PAY_EXT 6'h2f
`define UTD_PID_MASK 6'h30
`define UTD_PID_MSB 3
`define UTD_PID_LSB 0
`define UTD_CODE_IDLE 2'h0
`define UTD_CODE_TX 2'h1
`define UTD_CODE_WR 2'h2
`define UTD_CODE_RD 2'h3
`define UTD_BYTE_RST 8'h00
`endif

/* File: utd_pkg.sv */
// types for the transmit-command decoder
package utd_pkg;
    typedef enum logic [2:0] {
        UTD_CMD_NONE,
        UTD_CMD_NOPID,
        UTD_CMD_PID,
        UTD_CMD_REGW,
        UTD_CMD_EXTW,
        UTD_CMD_REGR,
        UTD_CMD_EXTR,
        UTD_CMD_BAD
    } utd_cmd_t;
    typedef struct packed {
        utd_cmd_t cmd;
        logic [3:0] pid;
        logic [7:0] addr;
        logic ext;
    } utd_dec_t;
endpackage : utd_pkg

/* File: utd_txcmd_decoder.sv */
// transmit-command byte decoder on the link data bus
// ==========================================================
// How it works
// - decoder raises nxt on accepting a command; link then sends bytes
// - code 0 payload 0 is idle; nothing happens
// - code 1 payload 0 is a transmit without packet identifier
// - no-pid transmit starts line drive only after next byte accepted
// - code 1 payload 00xxxx is packet transmit, pid from bits 3:0
// - code 2 payload 101111 is extended write; address byte follows
// - code 2 other payload is write with 6-bit immediate address
// - code 3 payload 101111 is extended read; address byte follows
// - code 3 other payload is read with 6-bit immediate address
// ==========================================================
// Limits
// the read turnaround after a register read is left to the bus owner;
// this block only decodes and accepts, it holds no register file
// an illegal byte is flagged and dropped rather than guessed at
// while nxt is high the bus carries data, so no command is taken then
`timescale 1ns/1ps
`include "utd_defines.svh"
module utd_txcmd_decoder
    import utd_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    // link bus
    input wire logic [7:0] data_in,
    input wire logic dir_in,
    input wire logic stp_in,
    // answers and decoded results
    output logic nxt_out,
    output utd_dec_t cmd_out,
    output logic cmd_valid_out,
    output logic tx_start_out,
    output logic [7:0] tx_byte_out,
    output logic tx_byte_valid_out,
    output logic illegal_out
);
    // ==========================================================
    // decode
    // purely combinational view of the byte now on the bus
    // st_q tracks which byte the link will send next
    typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA} st_t;
    st_t st_q, st_d;
    utd_dec_t dec, cmd_q, cmd_d;
    logic [1:0] code;
    logic [5:0] pay;
    logic cv_q, cv_d;
    logic ts_q, ts_d;
    logic tv_q, tv_d;
    logic il_q, il_d;
    logic nxt_q, nxt_d;
    logic started_q, started_d;
    logic take_ok;
    logic [7:0] tb_q, tb_d;

    always_comb begin
        code = data_in[`UTD_CODE_MSB:`UTD_CODE_LSB];
        pay = data_in[`UTD_PAY_MSB:`UTD_PAY_LSB];
        dec = '0;
        dec.cmd = UTD_CMD_NONE;
        case (code)
            `UTD_CODE_IDLE: begin
                // any nonzero payload here is undefined
                dec.cmd = (pay == `UTD_PAY_NONE) ? UTD_CMD_NONE
                                                 : UTD_CMD_BAD;
            end
            `UTD_CODE_TX: begin
                if (pay == `UTD_PAY_NONE) begin
                    dec.cmd = UTD_CMD_NOPID;
                end else if ((pay & `UTD_PID_MASK) == `UTD_PAY_NONE) begin
                    dec.cmd = UTD_CMD_PID;
                    dec.pid = pay[`UTD_PID_MSB:`UTD_PID_LSB];
                end else begin
                    dec.cmd = UTD_CMD_BAD;
                end
            end
            `UTD_CODE_WR: begin
                dec.ext = (pay == `UTD_PAY_EXT);
                dec.cmd = dec.ext ? UTD_CMD_EXTW : UTD_CMD_REGW;
                dec.addr = {2'h0, pay};
            end
            `UTD_CODE_RD: begin
                dec.ext = (pay == `UTD_PAY_EXT);
                dec.cmd = dec.ext ? UTD_CMD_EXTR : UTD_CMD_REGR;
                dec.addr = {2'h0, pay};
            end
            default: dec.cmd = UTD_CMD_BAD;
        endcase
    end

    // ==========================================================
    // sequencing
    // a byte is a command only when the bus faces us and no data phase
    // is under way; nxt still high means the link is driving data
    assign take_ok = !dir_in && !nxt_q;

    // nxt is registered: the command is seen, then accepted one cycle later
    always_comb begin
        st_d = st_q;
        cmd_d = cmd_q;
        cv_d = 1'b0;
        ts_d = 1'b0;
        tv_d = 1'b0;
        il_d = 1'b0;
        nxt_d = 1'b0;
        tb_d = tb_q;
        case (st_q)
            ST_IDLE: begin
                // illegal bytes get no nxt, so the link sees them refused
                if (take_ok && dec.cmd == UTD_CMD_BAD) begin
                    il_d = 1'b1;
                end else if (take_ok && dec.cmd != UTD_CMD_NONE) begin
                    cmd_d = dec;
                    cv_d = 1'b1;
                    nxt_d = 1'b1;
                    // an immediate read goes straight back to idle
                    if (dec.ext) begin
                        st_d = ST_ADDR;
                    end else if (dec.cmd == UTD_CMD_PID ||
                                 dec.cmd == UTD_CMD_NOPID ||
                                 dec.cmd == UTD_CMD_REGW) begin
                        st_d = ST_DATA;
                    end
                    // pid transmit starts at acceptance of the command
                    ts_d = (dec.cmd == UTD_CMD_PID);
                end
            end
            ST_ADDR: begin
                // the address byte is taken on the first edge with nxt high
                nxt_d = 1'b1;
                if (nxt_q) begin
                    cmd_d.addr = data_in;
                    cv_d = 1'b1;
                    st_d = (cmd_q.cmd == UTD_CMD_EXTW) ? ST_DATA : ST_IDLE;
                    nxt_d = (cmd_q.cmd == UTD_CMD_EXTW);
                end
            end
            ST_DATA: begin
                // stop or a bus turn ends the phase; that byte is not kept
                nxt_d = 1'b1;
                if (stp_in || dir_in) begin
                    st_d = ST_IDLE;
                    nxt_d = 1'b0;
                end else if (nxt_q) begin
                    tb_d = data_in;
                    tv_d = 1'b1;
                    // line drive waits for the first accepted data byte
                    if (cmd_q.cmd == UTD_CMD_NOPID && !started_q) begin
                        ts_d = 1'b1;
                    end
                    if (cmd_q.cmd == UTD_CMD_REGW ||
                        cmd_q.cmd == UTD_CMD_EXTW) begin
                        st_d = ST_IDLE;
                        nxt_d = 1'b0;
                    end
                end
            end
            default: st_d = ST_IDLE;
        endcase
    end

    // the clock enable freezes every register, outputs included
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            st_q <= ST_IDLE;
            cmd_q <= '0;
            cv_q <= 1'b0;
            ts_q <= 1'b0;
            tv_q <= 1'b0;
            il_q <= 1'b0;
            nxt_q <= 1'b0;
            tb_q <= `UTD_BYTE_RST;
        end else if (clk_en_in) begin
            st_q <= st_d;
            cmd_q <= cmd_d;
            cv_q <= cv_d;
            ts_q <= ts_d;
            tv_q <= tv_d;
            il_q <= il_d;
            nxt_q <= nxt_d;
            tb_q <= tb_d;
        end
    end

    // ==========================================================
    // line-drive tracking
    // a no-pid transmit may carry many bytes; start must pulse once only,
    // so remember that the first byte has gone out until the bus is idle
    always_comb begin
        started_d = started_q;
        if (st_q == ST_IDLE) begin
            started_d = 1'b0;
        end else if (tv_d) begin
            started_d = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            started_q <= 1'b0;
        end else if (clk_en_in) begin
            started_q <= started_d;
        end
    end

    // ==========================================================
    // outputs
    // every output is a flop or a straight copy of one

    assign nxt_out = nxt_q;
    assign cmd_out = cmd_q;
    assign cmd_valid_out = cv_q;
    assign tx_start_out = ts_q;
    assign tx_byte_out = tb_q;
    assign tx_byte_valid_out = tv_q;
    assign illegal_out = il_q;
endmodule : utd_txcmd_decoder

/* File: utd_txcmd_decoder_assertions.sv */
// checker for the transmit-command decoder ports
`timescale 1ns/1ps
module utd_txcmd_decoder_assertions
    import utd_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    input wire logic [7:0] data_in,
    input wire logic dir_in,
    input wire logic nxt_out,
    input wire utd_dec_t cmd_out,
    input wire logic cmd_valid_out,
    input wire logic tx_start_out,
    input wire logic illegal_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    // legal only with a nonzero code; code 1 needs payload bits 5:4 clear
    wire ok = data_in[7] || data_in[7:4] == 4'h4;
    sequence s_take;
        !nxt_out && clk_en_in && !dir_in && data_in != 8'h00;
    endsequence
    sequence s_extr;
        s_take ##0 data_in == 8'hef ##1 clk_en_in && !dir_in;
    endsequence
    property p_acc; s_take ##0 ok |=> nxt_out && cmd_valid_out; endproperty
    a_acc: assert property (p_acc) else $error("no accept");
    property p_bad; s_take ##0 !ok |=> illegal_out && !nxt_out; endproperty
    a_bad: assert property (p_bad) else $error("bad taken");
    property p_nop; s_take ##0 data_in == 8'h40
        |=> !tx_start_out && cmd_out.cmd == UTD_CMD_NOPID; endproperty
    a_nop: assert property (p_nop) else $error("no-pid");
    property p_pid; s_take ##0 data_in[7:4] == 4'h4 && data_in[3:0] != 4'h0
        |=> tx_start_out && cmd_out.pid == $past(data_in[3:0]); endproperty
    a_pid: assert property (p_pid) else $error("pid");
    property p_wr; s_take ##0 data_in[7:6] == 2'h2 && data_in[5:0] != 6'h2f
        |=> cmd_out.cmd == UTD_CMD_REGW
        && cmd_out.addr == {2'h0, $past(data_in[5:0])}; endproperty
    a_wr: assert property (p_wr) else $error("write");
    property p_rd; s_take ##0 data_in[7:6] == 2'h3 && data_in[5:0] != 6'h2f
        |=> cmd_out.cmd == UTD_CMD_REGR
        && cmd_out.addr == {2'h0, $past(data_in[5:0])}; endproperty
    a_rd: assert property (p_rd) else $error("read");
    property p_ew; s_take ##0 data_in == 8'haf
        |=> cmd_out.cmd == UTD_CMD_EXTW && cmd_out.ext; endproperty
    a_ew: assert property (p_ew) else $error("ext write");
    property p_er; s_extr
        |=> cmd_valid_out && !nxt_out && cmd_out.addr == $past(data_in);
    endproperty
    a_er: assert property (p_er) else $error("ext read");
endmodule : utd_txcmd_decoder_assertions
bind utd_txcmd_decoder utd_txcmd_decoder_assertions chk_u (.*);

/* File: utd_link_model.sv */
// link-side model driving command and follow-up bytes
`timescale 1ns/1ps
module utd_link_model (
    input wire logic clk_sys_in,
    input wire logic clk_en_in,
    input wire logic nxt_out,
    input wire logic go,
    input wire logic [7:0] cmd,
    input wire logic [7:0] dat,
    input wire logic [7:0] len,
    output logic [7:0] data_in,
    output logic stp_in
);
    logic [7:0] cnt_q = 8'h00;
    // the link counts bytes only on edges the transceiver also takes
    always_ff @(posedge clk_sys_in) begin
        if (clk_en_in) cnt_q <= nxt_out ? cnt_q + 8'h01 : 8'h00;
    end
    // bytes advance only while nxt is high; otherwise the bus carries cmd while go is high, else zero
    assign data_in = nxt_out ? dat + cnt_q
        : go ? cmd : 8'h00;
    assign stp_in = nxt_out && cnt_q == len;
endmodule : utd_link_model

/* File: tb_ulpi_txcmd_decoder.sv */
// self-checking bench for the transmit-command decoder
`timescale 1ns/1ps
module tb_ulpi_txcmd_decoder;
    import utd_pkg::*;
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
    error_cnt++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
    logic clk_sys_in = 1'b0, rst_in = 1'b1, clk_en_in = 1'b1, dir_in = 1'b0;
    logic go = 1'b0, stp_in, nxt_out, cmd_valid_out, tx_start_out;
    logic tx_byte_valid_out, illegal_out;
    logic [7:0] cmd = 8'h00, dat = 8'h00, len = 8'h00, data_in, tx_byte_out;
    utd_dec_t cmd_out;
    int error_cnt = 0, comparisons = 0, n;
    always #2 clk_sys_in = ~clk_sys_in;
    utd_link_model link_u (.*);
    utd_txcmd_decoder dut_u (.*);
    task automatic tick; @(posedge clk_sys_in); #1; endtask : tick
    task automatic send(input logic [7:0] c, d, l, input logic v);
        @(posedge clk_sys_in);
        {go, cmd, dat, len} <= {1'b1, c, d, l};
        @(posedge clk_sys_in);
        go <= 1'b0;
        #1;
        `CHK("accept", v, nxt_out & cmd_valid_out)
    endtask : send
    task automatic t_bad;
        send(8'h05, 8'h00, 8'hff, 1'b0);
        `CHK("illegal 05", 1'b1, illegal_out)
        send(8'h50, 8'h00, 8'hff, 1'b0);
        `CHK("illegal 50", 1'b1, illegal_out)
        tick;
        `CHK("idle", 1'b0, cmd_valid_out | nxt_out)
        dir_in <= 1'b1;
        send(8'h85, 8'h00, 8'hff, 1'b0);
        dir_in <= 1'b0;
    endtask : t_bad
    task automatic t_reg;
        send(8'h85, 8'h5a, 8'hff, 1'b1);
        `CHK("regw", {UTD_CMD_REGW, 8'h05},
            {cmd_out.cmd, cmd_out.addr})
        tick;
        `CHK("regw byte", {8'h5a, 1'b0},
            {tx_byte_out, nxt_out})
        send(8'hf0, 8'h00, 8'hff, 1'b1);
        `CHK("regr", {UTD_CMD_REGR, 8'h30},
            {cmd_out.cmd, cmd_out.addr})
        send(8'hef, 8'h80, 8'hff, 1'b1);
        tick;
        `CHK("extr", {1'b1, 8'h80},
            {cmd_out.ext, cmd_out.addr})
        send(8'haf, 8'h21, 8'hff, 1'b1);
        `CHK("extw", UTD_CMD_EXTW, cmd_out.cmd)
        tick;
        `CHK("extw addr", 8'h21, cmd_out.addr)
        tick;
        `CHK("extw data", 8'h22, tx_byte_out)
    endtask : t_reg
    task automatic t_tx;
        send(8'h40, 8'h33, 8'h03, 1'b1);
        `CHK("nopid", {UTD_CMD_NOPID, 1'b0},
            {cmd_out.cmd, tx_start_out})
        tick;
        `CHK("nopid start", {2'h3, 8'h33},
            {tx_start_out, tx_byte_valid_out, tx_byte_out})
        tick;
        tick;
        `CHK("nopid once", {1'b0, 1'b1, 8'h35},
            {tx_start_out, tx_byte_valid_out, tx_byte_out})
        tick;
        send(8'h43, 8'h10, 8'h02, 1'b1);
        `CHK("pid", {4'h3, 1'b1}, {cmd_out.pid, tx_start_out})
        n = 0;
        for (int i = 0; i < 8 && nxt_out === 1'b1; i++) begin
            tick;
            if (tx_byte_valid_out === 1'b1) n++;
        end
        `CHK("pid bytes", {32'd2, 8'h11, 1'b0},
            {n, tx_byte_out, nxt_out})
    endtask : t_tx
    task automatic t_hold;
        send(8'h85, 8'h66, 8'hff, 1'b1);
        clk_en_in <= 1'b0;
        repeat (3) tick;
        `CHK("hold", {1'b1, 1'b0}, {nxt_out, tx_byte_valid_out})
        clk_en_in <= 1'b1;
        tick;
        `CHK("hold byte", {8'h66, 1'b1, 1'b0},
            {tx_byte_out, tx_byte_valid_out, nxt_out})
    endtask : t_hold
    task automatic wrap_up;
        if (error_cnt == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (20) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        t_bad;
        t_reg;
        t_tx;
        t_hold;
        wrap_up;
    end
endmodule : tb_ulpi_txcmd_decoder
